/* File: fcp_pkg.sv */
// shared constants, field layouts and carrier types for the command parameter block
package fcp_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TIMING = 8'h04;
  localparam logic [7:0] ADR_CONFIG = 8'h08;
  localparam logic [7:0] ADR_CMD = 8'h0C;
  localparam logic [7:0] ADR_SECT = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_INT_STAT = 8'h18;
  localparam logic [7:0] ADR_INT_MASK = 8'h1C;
  localparam logic [7:0] ADR_DATA = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SRST = 0;
  localparam int CTRL_LOCK = 1;
  localparam int TIM_SETTLE_LSB = 0;
  localparam int TIM_RELEASE_LSB = 8;
  localparam int CFG_FIFO_EN_N = 0;
  localparam int CFG_THR_LSB = 4;
  localparam int CFG_PRECOMP_LSB = 8;
  localparam int CMD_SIZE_LSB = 0;
  localparam int CMD_NODMA = 5;
  localparam int CMD_MFM = 6;
  localparam int CMD_MT = 7;
  localparam int CMD_HEAD = 8;
  localparam int CMD_GO_RD = 16;
  localparam int CMD_GO_WR = 17;
  localparam int SECT_FIRST_LSB = 0;
  localparam int SECT_LAST_LSB = 8;
  localparam int SECT_SHORT_LSB = 16;
  localparam int INT_BYTE = 0;
  localparam int INT_DONE = 1;
  localparam int INT_W = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_FIFO_EN_N = 1'b1;
  localparam logic [3:0] RST_FIFO_THR = 4'h0;
  localparam logic [7:0] RST_PRECOMP = 8'h00;
  localparam logic [7:0] RST_SETTLE = 8'h01;
  localparam logic [7:0] RST_RELEASE = 8'h01;
  localparam logic [7:0] RST_FIRST = 8'h01;
  localparam logic [7:0] RST_LAST = 8'h01;
  localparam logic [7:0] RST_SHORT = 8'hFF;

  // ----------------------------------------------------------------
  // sector geometry and timing
  // ----------------------------------------------------------------
  localparam logic [14:0] BASE_SECTOR_BYTES = 15'h0080;
  localparam logic [7:0] HEAD1_FIRST_SECTOR = 8'h01;
  localparam int CLK_MHZ = 20;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    FCP_IDLE = 5'b00001,
    FCP_SETTLE = 5'b00010,
    FCP_XFER = 5'b00100,
    FCP_HOST = 5'b01000,
    FCP_DONE = 5'b10000
  } fcp_state_e;

  typedef struct packed {
    logic fifo_enable_n;
    logic [3:0] fifo_threshold;
    logic [7:0] precomp_start_cylinder;
  } fcp_cfg_s;

  typedef struct packed {
    logic multi_track_flag;
    logic mfm;
    logic no_dma_flag;
    logic [2:0] size_code;
  } fcp_cmd_s;

endpackage

/* File: fcp_decode.sv */
// command parameter decode, head timing and byte transfer sequencing
//
// How it works
// - after the head is loaded the sequencer waits the settle count before any medium byte.
// - when an execution ends the release count runs and the head drops when it expires.
// - a soft reset restores fifo and precomp settings only while the lock bit is clear.
// - the density bit selects mfm when one and fm when zero, driven on mfm_mode.
// - with multi-track set the last head 0 sector continues with the first head 1 sector.
// - a nonzero size code gives 128 shifted left by the code bytes, codes 1 to 7.
// - size code zero gives 128 byte sectors with the short length bytes passed to the host.
// - with no-dma set each data byte raises the byte interrupt and waits for a data access.
// - with no-dma clear each data byte raises dma_request and waits for dma_acknowledge.
// - bytes past the short length are read but withheld, or written as zero.
// - fifo_enable_n is active low and resets to one, fifo disabled.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ns
module fcp_decode #(
  parameter int TICK_CYCLES = fcp_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // dma handshake
  output logic dma_request,
  input wire logic dma_acknowledge,
  input wire logic [7:0] dma_wr_data,
  output logic [7:0] dma_rd_data,
  // medium side
  input wire logic media_byte_tick,
  input wire logic [7:0] media_rd_byte,
  output logic [7:0] media_wr_byte,
  output logic media_wr_strobe,
  output logic head_load,
  output logic head_select,
  output logic mfm_mode,
  // configuration and interrupt
  output fcp_pkg::fcp_cfg_s cfg_out,
  output logic irq
);

  localparam int DIV_W = $clog2(TICK_CYCLES);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  fcp_pkg::fcp_state_e state;
  fcp_pkg::fcp_cfg_s cfg;
  fcp_pkg::fcp_cmd_s cmd;
  logic lock;
  logic [7:0] settle_cnt;
  logic [7:0] release_cnt;
  logic [7:0] first_sector;
  logic [7:0] last_sector;
  logic [7:0] short_len;
  logic [7:0] sector;
  logic [14:0] idx;
  logic [7:0] host_byte;
  logic have_byte;
  logic is_write;
  logic finish;
  logic byte_evt;
  logic done_evt;
  logic [2:0] ack_sync;
  logic [7:0] wdat_s1;
  logic [7:0] wdat_s2;
  logic [DIV_W-1:0] div;
  logic ms_tick;
  logic [7:0] ivl_cnt;
  logic releasing;
  logic [fcp_pkg::INT_W-1:0] int_stat;
  logic [fcp_pkg::INT_W-1:0] int_mask;
  logic [fcp_pkg::INT_W-1:0] next_int_stat;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == fcp_pkg::ADR_CTRL);
  wire wr_timing = reg_wr && (reg_addr == fcp_pkg::ADR_TIMING);
  wire wr_config = reg_wr && (reg_addr == fcp_pkg::ADR_CONFIG);
  wire wr_cmd = reg_wr && (reg_addr == fcp_pkg::ADR_CMD);
  wire wr_sect = reg_wr && (reg_addr == fcp_pkg::ADR_SECT);
  wire wr_mask = reg_wr && (reg_addr == fcp_pkg::ADR_INT_MASK);
  wire wr_data = reg_wr && (reg_addr == fcp_pkg::ADR_DATA);
  wire rd_data = reg_rd && (reg_addr == fcp_pkg::ADR_DATA);
  wire rd_stat = reg_rd && (reg_addr == fcp_pkg::ADR_INT_STAT);
  wire soft_reset = wr_ctrl && reg_wdata[fcp_pkg::CTRL_SRST];
  wire idle = (state == fcp_pkg::FCP_IDLE);
  wire go_rd = wr_cmd && idle && reg_wdata[fcp_pkg::CMD_GO_RD];
  wire go_wr = wr_cmd && idle && !go_rd && reg_wdata[fcp_pkg::CMD_GO_WR];
  wire go = go_rd || go_wr;
  wire ack_edge = ack_sync[1] && !ack_sync[2];

  // sector length and the part of it the host sees
  wire [14:0] phys_len = fcp_pkg::BASE_SECTOR_BYTES << cmd.size_code;
  wire [14:0] xfer_len = (cmd.size_code == 3'h0) ? {7'h00, short_len} : phys_len;
  wire in_xfer = idx < xfer_len;
  wire last_byte = (idx == phys_len - 15'h0001);
  wire to_head1 = cmd.multi_track_flag && !head_select && (sector == last_sector);
  wire sect_end_done = last_byte && (sector == last_sector) && !to_head1;
  wire service = (state == fcp_pkg::FCP_HOST) &&
    (cmd.no_dma_flag ? (is_write ? wr_data : rd_data) : ack_edge);

  assign cfg_out = cfg;
  assign mfm_mode = cmd.mfm;
  assign dma_rd_data = host_byte;

  // ----------------------------------------------------------------
  // acknowledge and dma write data synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_sync <= 3'h0;
      wdat_s1 <= 8'h00;
      wdat_s2 <= 8'h00;
    end else begin
      ack_sync <= {ack_sync[1:0], dma_acknowledge};
      wdat_s1 <= dma_wr_data;
      wdat_s2 <= wdat_s1;
    end
  end

  // ----------------------------------------------------------------
  // configuration, lock and timing counts
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || (soft_reset && !lock)) begin
      cfg.fifo_enable_n <= fcp_pkg::RST_FIFO_EN_N;
      cfg.fifo_threshold <= fcp_pkg::RST_FIFO_THR;
      cfg.precomp_start_cylinder <= fcp_pkg::RST_PRECOMP;
    end else if (wr_config) begin
      cfg.fifo_enable_n <= reg_wdata[fcp_pkg::CFG_FIFO_EN_N];
      cfg.fifo_threshold <= reg_wdata[fcp_pkg::CFG_THR_LSB +: 4];
      cfg.precomp_start_cylinder <= reg_wdata[fcp_pkg::CFG_PRECOMP_LSB +: 8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock <= 1'b0;
    end else if (wr_ctrl) begin
      lock <= reg_wdata[fcp_pkg::CTRL_LOCK];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settle_cnt <= fcp_pkg::RST_SETTLE;
      release_cnt <= fcp_pkg::RST_RELEASE;
      first_sector <= fcp_pkg::RST_FIRST;
      last_sector <= fcp_pkg::RST_LAST;
      short_len <= fcp_pkg::RST_SHORT;
      int_mask <= '0;
    end else begin
      if (wr_timing) begin
        settle_cnt <= reg_wdata[fcp_pkg::TIM_SETTLE_LSB +: 8];
        release_cnt <= reg_wdata[fcp_pkg::TIM_RELEASE_LSB +: 8];
      end
      if (wr_sect) begin
        first_sector <= reg_wdata[fcp_pkg::SECT_FIRST_LSB +: 8];
        last_sector <= reg_wdata[fcp_pkg::SECT_LAST_LSB +: 8];
        short_len <= reg_wdata[fcp_pkg::SECT_SHORT_LSB +: 8];
      end
      if (wr_mask) begin
        int_mask <= reg_wdata[fcp_pkg::INT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick and head load timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || soft_reset) begin
      div <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (div == DIV_W'(TICK_CYCLES - 1));
      div <= (div == DIV_W'(TICK_CYCLES - 1)) ? '0 : div + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || soft_reset) begin
      head_load <= 1'b0;
      ivl_cnt <= 8'h00;
      releasing <= 1'b0;
    end else if (go) begin
      releasing <= 1'b0;
      head_load <= 1'b1;
      ivl_cnt <= head_load ? 8'h00 : settle_cnt;
    end else if (state == fcp_pkg::FCP_DONE) begin
      releasing <= 1'b1;
      ivl_cnt <= release_cnt;
    end else if (ms_tick && (ivl_cnt != 8'h00)) begin
      ivl_cnt <= ivl_cnt - 8'h01;
    end else if (releasing && (ivl_cnt == 8'h00)) begin
      head_load <= 1'b0;
      releasing <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || soft_reset) begin
      state <= fcp_pkg::FCP_IDLE;
      cmd <= '0;
      head_select <= 1'b0;
      sector <= 8'h00;
      idx <= 15'h0000;
      host_byte <= 8'h00;
      have_byte <= 1'b0;
      is_write <= 1'b0;
      finish <= 1'b0;
      dma_request <= 1'b0;
      byte_evt <= 1'b0;
      done_evt <= 1'b0;
      media_wr_byte <= 8'h00;
      media_wr_strobe <= 1'b0;
    end else begin
      byte_evt <= 1'b0;
      done_evt <= 1'b0;
      media_wr_strobe <= 1'b0;
      case (state)
        fcp_pkg::FCP_IDLE: begin
          if (go) begin
            cmd.multi_track_flag <= reg_wdata[fcp_pkg::CMD_MT];
            cmd.mfm <= reg_wdata[fcp_pkg::CMD_MFM];
            cmd.no_dma_flag <= reg_wdata[fcp_pkg::CMD_NODMA];
            cmd.size_code <= reg_wdata[fcp_pkg::CMD_SIZE_LSB +: 3];
            head_select <= reg_wdata[fcp_pkg::CMD_HEAD];
            sector <= first_sector;
            idx <= 15'h0000;
            have_byte <= 1'b0;
            finish <= 1'b0;
            is_write <= go_wr;
            state <= head_load ? fcp_pkg::FCP_XFER : fcp_pkg::FCP_SETTLE;
          end
        end
        fcp_pkg::FCP_SETTLE: begin
          if (ivl_cnt == 8'h00) begin
            state <= fcp_pkg::FCP_XFER;
          end
        end
        fcp_pkg::FCP_XFER: begin
          if (is_write && in_xfer && !have_byte) begin
            state <= fcp_pkg::FCP_HOST;
            dma_request <= !cmd.no_dma_flag;
            byte_evt <= cmd.no_dma_flag;
          end else if (media_byte_tick) begin
            if (is_write) begin
              media_wr_byte <= in_xfer ? host_byte : 8'h00;
              media_wr_strobe <= 1'b1;
              have_byte <= 1'b0;
              state <= sect_end_done ? fcp_pkg::FCP_DONE : fcp_pkg::FCP_XFER;
            end else begin
              host_byte <= media_rd_byte;
              if (in_xfer) begin
                state <= fcp_pkg::FCP_HOST;
                dma_request <= !cmd.no_dma_flag;
                byte_evt <= cmd.no_dma_flag;
              end else begin
                state <= sect_end_done ? fcp_pkg::FCP_DONE : fcp_pkg::FCP_XFER;
              end
            end
            if (last_byte) begin
              idx <= 15'h0000;
              finish <= sect_end_done;
              if (to_head1) begin
                head_select <= 1'b1;
                sector <= fcp_pkg::HEAD1_FIRST_SECTOR;
              end else begin
                sector <= sector + 8'h01;
              end
            end else begin
              idx <= idx + 15'h0001;
            end
          end
        end
        fcp_pkg::FCP_HOST: begin
          if (service) begin
            dma_request <= 1'b0;
            if (is_write) begin
              host_byte <= cmd.no_dma_flag ? reg_wdata[7:0] : wdat_s2;
              have_byte <= 1'b1;
            end
            state <= finish ? fcp_pkg::FCP_DONE : fcp_pkg::FCP_XFER;
          end
        end
        fcp_pkg::FCP_DONE: begin
          done_evt <= 1'b1;
          state <= fcp_pkg::FCP_IDLE;
        end
        default: begin
          state <= fcp_pkg::FCP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, set wins over the read clear
  // ----------------------------------------------------------------
  always_comb begin
    next_int_stat = rd_stat ? '0 : int_stat;
    next_int_stat[fcp_pkg::INT_BYTE] = next_int_stat[fcp_pkg::INT_BYTE] | byte_evt;
    next_int_stat[fcp_pkg::INT_DONE] = next_int_stat[fcp_pkg::INT_DONE] | done_evt;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_stat <= '0;
      irq <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq <= |(int_stat & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // read data, valid only the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        fcp_pkg::ADR_CTRL: reg_rdata <= {30'h0, lock, 1'b0};
        fcp_pkg::ADR_TIMING: reg_rdata <= {16'h0000, release_cnt, settle_cnt};
        fcp_pkg::ADR_CONFIG: reg_rdata <= {16'h0000, cfg.precomp_start_cylinder,
          cfg.fifo_threshold, 3'h0, cfg.fifo_enable_n};
        fcp_pkg::ADR_CMD: reg_rdata <= {23'h0, head_select, cmd.multi_track_flag,
          cmd.mfm, cmd.no_dma_flag, 2'h0, cmd.size_code};
        fcp_pkg::ADR_SECT: reg_rdata <= {8'h00, short_len, last_sector, first_sector};
        fcp_pkg::ADR_STATUS: reg_rdata <= {11'h0, state, sector, 4'h0,
          dma_request, head_select, head_load, !idle};
        fcp_pkg::ADR_INT_STAT: reg_rdata <= {30'h0, int_stat};
        fcp_pkg::ADR_INT_MASK: reg_rdata <= {30'h0, int_mask};
        fcp_pkg::ADR_DATA: reg_rdata <= {24'h00_0000, host_byte};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // fcp_decode

/* File: fcp_monitor.sv */
// checker for the command parameter block ports
`timescale 1ns/1ns
module fcp_monitor #(
  parameter int TICK_CYCLES = fcp_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // dma and medium
  input wire logic dma_request,
  input wire logic dma_acknowledge,
  input wire logic [7:0] media_wr_byte,
  input wire logic media_wr_strobe,
  input wire logic head_load,
  input wire logic head_select,
  input wire logic mfm_mode,
  input wire fcp_pkg::fcp_cfg_s cfg_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // shadows of the programmed parameters
  // ----------------------------------------
  logic lock_q;
  logic [31:0] cmd_q;
  logic [7:0] settle_q;
  logic [7:0] short_q;
  logic [15:0] load_cnt;
  logic [15:0] wr_idx;
  logic ctrl_wr;
  logic cmd_wr;
  assign ctrl_wr = reg_wr && reg_addr == fcp_pkg::ADR_CTRL;
  assign cmd_wr = reg_wr && reg_addr == fcp_pkg::ADR_CMD;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_q <= 1'b0;
      cmd_q <= 32'h0000_0000;
      settle_q <= fcp_pkg::RST_SETTLE;
      short_q <= fcp_pkg::RST_SHORT;
    end else if (reg_wr) begin
      if (ctrl_wr) lock_q <= reg_wdata[fcp_pkg::CTRL_LOCK];
      if (cmd_wr) cmd_q <= reg_wdata;
      if (reg_addr == fcp_pkg::ADR_TIMING) settle_q <= reg_wdata[7:0];
      if (reg_addr == fcp_pkg::ADR_SECT) short_q <= reg_wdata[23:16];
    end
  end
  // cycles spent with the head loaded, saturating
  always_ff @(posedge clk_sys) begin
    if (rst || !head_load) load_cnt <= 16'h0000;
    else if (load_cnt != 16'hFFFF) load_cnt <= load_cnt + 16'h0001;
  end
  // medium bytes written since the last command
  always_ff @(posedge clk_sys) begin
    if (rst || cmd_wr) wr_idx <= 16'h0000;
    else if (media_wr_strobe) wr_idx <= wr_idx + 16'h0001;
  end
  a_cfg_reset_val: assert property (
    $past(rst) |-> cfg_out == 13'h1000)
    else $error("fifo settings not at default after reset");
  a_soft_clear: assert property (
    ctrl_wr && reg_wdata[0] && !lock_q |=> cfg_out == 13'h1000)
    else $error("unlocked soft reset kept fifo settings");
  a_mfm_applied: assert property (
    $rose(dma_request) || media_wr_strobe |-> mfm_mode == cmd_q[fcp_pkg::CMD_MFM])
    else $error("density output differs from command");
  a_head_one_mt: assert property (
    $rose(head_select) |-> cmd_q[fcp_pkg::CMD_MT] || cmd_q[fcp_pkg::CMD_HEAD])
    else $error("head 1 taken without multi-track");
  a_settle_wait: assert property (
    $rose(dma_request) || media_wr_strobe |->
      int'(load_cnt) >= (int'(settle_q) - 1) * TICK_CYCLES)
    else $error("medium access before head settle");
  a_ack_drops_req: assert property (
    $rose(dma_acknowledge) |-> ##[1:5] !dma_request)
    else $error("request not withdrawn after acknowledge");
  a_req_holds: assert property (
    dma_request && !dma_acknowledge && !ctrl_wr |=> dma_request)
    else $error("request dropped without acknowledge");
  a_no_dma_req: assert property (
    cmd_q[fcp_pkg::CMD_NODMA] |-> !$rose(dma_request))
    else $error("dma request in non-dma mode");
  a_short_fill: assert property (
    media_wr_strobe && cmd_q[2:0] == 3'h0 && {1'b0, wr_idx[6:0]} >= short_q
      |-> media_wr_byte == 8'h00)
    else $error("byte past short length not zero");
  c_multi_track: cover property ($rose(head_select));
  c_dma_service: cover property ($rose(dma_acknowledge) ##[1:5] $fell(dma_request));
  c_locked_reset: cover property (ctrl_wr && reg_wdata[0] && lock_q);
endmodule // fcp_monitor

bind fcp_decode fcp_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .dma_request(dma_request), .dma_acknowledge(dma_acknowledge),
  .media_wr_byte(media_wr_byte), .media_wr_strobe(media_wr_strobe), .head_load(head_load),
  .head_select(head_select), .mfm_mode(mfm_mode), .cfg_out(cfg_out)
);

/* File: fcp_dma_model.sv */
// behavioural dma controller answering the block's request handshake
`timescale 1ns/1ns
module fcp_dma_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // handshake
  input wire logic dma_request,
  output logic dma_acknowledge,
  output logic [7:0] dma_wr_data,
  // bench control and view
  input wire logic [3:0] ack_delay,
  output logic [15:0] got_count
);
  logic [3:0] wait_cnt;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dma_acknowledge <= 1'b0;
      wait_cnt <= 4'h0;
      got_count <= 16'h0000;
      dma_wr_data <= 8'h5A;
    end else if (dma_acknowledge) begin
      // hold the answer until the request is withdrawn
      if (!dma_request) begin
        dma_acknowledge <= 1'b0;
        dma_wr_data <= ~dma_wr_data;
      end
    end else if (dma_request) begin
      // answer each request after a chosen delay
      dma_wr_data <= 8'hA0 + got_count[7:0];
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == ack_delay) begin
        dma_acknowledge <= 1'b1;
        got_count <= got_count + 16'h0001;
        wait_cnt <= 4'h0;
      end
    end else begin
      // released data lines keep moving
      dma_wr_data <= ~dma_wr_data;
      wait_cnt <= 4'h0;
    end
  end
endmodule // fcp_dma_model

/* File: tb_floppy_command_parameter_decode.sv */
// self-checking bench for the command parameter block
`timescale 1ns/1ns
module tb_floppy_command_parameter_decode;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic media_byte_tick = 1'b0;
  logic [7:0] media_rd_byte = 8'h00;
  logic [3:0] ack_delay = 4'h0;
  logic [3:0] tick_div = 4'h0;
  logic [31:0] reg_rdata;
  logic [7:0] dma_wr_data, dma_rd_data, media_wr_byte;
  logic dma_request, dma_acknowledge, media_wr_strobe, head_load, head_select, mfm_mode, irq;
  fcp_pkg::fcp_cfg_s cfg_out;
  logic [15:0] got_count;
  logic [7:0] wr_nzb = 8'h00;
  logic ack_q = 1'b0;
  logic [7:0] host_prev = 8'h00;
  logic [7:0] host_last = 8'h00;
  int fail_count = 0;
  int checks = 0;
  int wr_seen = 0;
  int wr_nz = 0;

  always #25 clk_sys = ~clk_sys;

  // one medium byte every 16 cycles with counting content
  always @(posedge clk_sys) begin
    tick_div <= tick_div + 4'h1;
    media_byte_tick <= (tick_div == 4'hF);
    if (tick_div == 4'hF) media_rd_byte <= media_rd_byte + 8'h01;
    if (media_wr_strobe) wr_seen <= wr_seen + 1;
    if (media_wr_strobe && media_wr_byte !== 8'h00) begin
      wr_nz <= wr_nz + 1;
      wr_nzb <= media_wr_byte;
    end
    // byte offered to the dma side at each new acknowledge
    ack_q <= dma_acknowledge;
    if (dma_acknowledge && !ack_q) begin
      host_prev <= host_last;
      host_last <= dma_rd_data;
    end
  end

  fcp_decode #(.TICK_CYCLES(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_request(dma_request),
    .dma_acknowledge(dma_acknowledge), .dma_wr_data(dma_wr_data), .dma_rd_data(dma_rd_data),
    .media_byte_tick(media_byte_tick), .media_rd_byte(media_rd_byte),
    .media_wr_byte(media_wr_byte), .media_wr_strobe(media_wr_strobe), .head_load(head_load),
    .head_select(head_select), .mfm_mode(mfm_mode), .cfg_out(cfg_out), .irq(irq)
  );
  fcp_dma_model u_dma (
    .clk_sys(clk_sys), .rst(rst), .dma_request(dma_request), .dma_acknowledge(dma_acknowledge),
    .dma_wr_data(dma_wr_data), .ack_delay(ack_delay), .got_count(got_count)
  );

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h0000_0001;
    for (int i = 0; i < 5000 && s[0] !== 1'b0; i++) rd(fcp_pkg::ADR_STATUS, s);
    check(s[0], 32'h0000_0000);
  endtask
  task automatic close_out();
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_lock();
    logic [31:0] d;
    rd(fcp_pkg::ADR_CONFIG, d);
    check(d, 32'h0000_0001);
    rd(fcp_pkg::ADR_TIMING, d);
    check(d, 32'h0000_0101);
    rd(8'hFC, d);
    check(d, 32'h0000_0000);
    wr(fcp_pkg::ADR_CONFIG, 32'h0000_AB50);
    wr(fcp_pkg::ADR_CTRL, 32'h0000_0002);
    wr(fcp_pkg::ADR_CTRL, 32'h0000_0003);
    pause(2);
    check(cfg_out, 32'h0000_05AB);
    wr(fcp_pkg::ADR_CTRL, 32'h0000_0001);
    pause(2);
    check(cfg_out, 32'h0000_05AB);
    wr(fcp_pkg::ADR_CTRL, 32'h0000_0001);
    pause(2);
    check(cfg_out, 32'h0000_1000);
  endtask
  task automatic t_dma_read();
    logic [31:0] d;
    int n;
    n = got_count;
    wr(fcp_pkg::ADR_TIMING, 32'h0000_0602);
    wr(fcp_pkg::ADR_SECT, 32'h0002_0101);
    wr(fcp_pkg::ADR_INT_MASK, 32'h0000_0000);
    wr(fcp_pkg::ADR_CMD, 32'h0001_0040);
    rd(fcp_pkg::ADR_STATUS, d);
    check(d[20:16], 32'h0000_0002);
    check(mfm_mode, 32'h0000_0001);
    wait_idle();
    check(got_count - n, 32'h0000_0002);
    check(host_last, 8'(host_prev + 8'h01));
    check(head_load, 32'h0000_0001);
    pause(60);
    check(head_load, 32'h0000_0000);
    check(irq, 32'h0000_0000);
    wr(fcp_pkg::ADR_INT_MASK, 32'h0000_0002);
    pause(2);
    check(irq, 32'h0000_0001);
    rd(fcp_pkg::ADR_INT_STAT, d);
    check(d, 32'h0000_0002);
    pause(2);
    check(irq, 32'h0000_0000);
  endtask
  task automatic t_nodma_mt();
    logic [31:0] s;
    logic [31:0] d;
    logic [7:0] prev;
    int n;
    n = 0;
    prev = 8'h00;
    s = 32'h0000_0000;
    wr(fcp_pkg::ADR_SECT, 32'h00FF_0101);
    wr(fcp_pkg::ADR_INT_MASK, 32'h0000_0003);
    wr(fcp_pkg::ADR_CMD, 32'h0001_00A1);
    for (int i = 0; i < 2000 && s[1] !== 1'b1; i++) begin
      for (int j = 0; j < 40 && irq !== 1'b1; j++) pause(1);
      rd(fcp_pkg::ADR_INT_STAT, s);
      if (s[0] === 1'b1) begin
        rd(fcp_pkg::ADR_DATA, d);
        if (n > 0) check(d[7:0], 8'(prev + 8'h01));
        prev = d[7:0];
        n++;
      end
    end
    check(n, 32'h0000_0200);
    check(head_select, 32'h0000_0001);
    check(mfm_mode, 32'h0000_0000);
  endtask
  task automatic t_dma_write();
    int s0;
    int z0;
    logic [7:0] exp;
    s0 = wr_seen;
    z0 = wr_nz;
    exp = 8'hA0 + got_count[7:0];
    ack_delay <= 4'h4;
    wr(fcp_pkg::ADR_SECT, 32'h0001_0101);
    wr(fcp_pkg::ADR_CMD, 32'h0002_0000);
    wait_idle();
    check(wr_seen - s0, 32'h0000_0080);
    check(wr_nz - z0, 32'h0000_0001);
    check(wr_nzb, exp);
  endtask
  task automatic t_nodma_write();
    logic [31:0] s;
    int n;
    int z0;
    n = 0;
    z0 = wr_nz;
    rd(fcp_pkg::ADR_INT_STAT, s);
    s = 32'h0000_0000;
    wr(fcp_pkg::ADR_SECT, 32'h0002_0101);
    wr(fcp_pkg::ADR_CMD, 32'h0002_0020);
    for (int i = 0; i < 400 && s[1] !== 1'b1; i++) begin
      for (int j = 0; j < 40 && irq !== 1'b1; j++) pause(1);
      rd(fcp_pkg::ADR_INT_STAT, s);
      if (s[0] === 1'b1) begin
        wr(fcp_pkg::ADR_DATA, 32'h0000_003C + n);
        n++;
      end
    end
    check(n, 32'h0000_0002);
    check(wr_nz - z0, 32'h0000_0002);
    check(wr_nzb, 8'h3D);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_lock();
    t_dma_read();
    t_nodma_mt();
    t_dma_write();
    t_nodma_write();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    close_out();
  end
endmodule // tb_floppy_command_parameter_decode
